// ===== psc_regs.vh
// What this block does
// (RULE_01) no group input active: default group
// (RULE_02) active group input selects its group
// (RULE_03) priority order resolves several active inputs
// (RULE_04) each group picks any discrete input
// (RULE_05) virtual inputs also control groups
// (RULE_06) stage reports idle, blocked, start or trip
// (RULE_07) start asserts when fault detected
// (RULE_08) trip after delay; abandon if fault clears
// (RULE_09) trip held while fault persists
// (RULE_10) blocked stage reports blocked, no pickup
// (RULE_11) blocking freezes delay counter
// (RULE_12) blocking after trip has no effect
// (RULE_13) non-arc stages blockable via block matrix
// (RULE_14) fixed internal blocking, e.g. no voltage
// (RULE_15) test force gives start/trip half second
// (RULE_16) force flag clears five minutes after keys
// (RULE_17) force flag permits direct relay forcing
// (RULE_18) matrix routes start/trip to outputs
// (RULE_19) cleared fault drops out under 50 ms
// (RULE_20) reset delay then release unless latched
// (RULE_21) reset delay below 95 ms
// (RULE_22) comparators apply hysteresis dead band
// (RULE_23) release beyond pickup minus/plus dead band
`ifndef PSC_REGS_VH
`define PSC_REGS_VH
`define PSC_CLK_HZ        10000000
`define PSC_NSTAGE        4
`define PSC_NOUT          8
`define PSC_NSRC          16
`define PSC_A_GROUP       12'h000
`define PSC_A_GRPSEL      12'h004
`define PSC_A_FORCE       12'h008
`define PSC_A_KEY         12'h00C
`define PSC_A_STATUS      12'h010
`define PSC_A_OUTMAP      12'h014
`define PSC_A_BLKMAP      12'h018
`define PSC_A_STGCFG      12'h01C
`define PSC_A_RELAY       12'h020
`define PSC_A_STGSEL      12'h024
`define PSC_A_ANALOG      12'h028
`define PSC_STGSEL_W      2
`define PSC_FORCE_MS      500
`define PSC_FORCE_CYC     ((`PSC_CLK_HZ / 1000) * `PSC_FORCE_MS)
`define PSC_TOUT_S        300
`define PSC_TOUT_CYC      (`PSC_CLK_HZ * `PSC_TOUT_S)
`define PSC_RESET_MS      80
`define PSC_RESET_CYC     ((`PSC_CLK_HZ / 1000) * `PSC_RESET_MS)
`define PSC_RETARD_MS     40
`define PSC_RETARD_CYC    ((`PSC_CLK_HZ / 1000) * `PSC_RETARD_MS)
`endif

// ===== psc_top.v
`timescale 1ns/1ns
`include "psc_regs.vh"
module psc_top #(
    parameter [31:0] TOUT_CYC   = `PSC_TOUT_CYC,
    parameter [31:0] FORCE_CYC  = `PSC_FORCE_CYC,
    parameter [31:0] RESET_CYC  = `PSC_RESET_CYC,
    parameter [31:0] RETARD_CYC = `PSC_RETARD_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  discrete_input,
    input  wire [7:0]  virtual_input,
    input  wire        panel_key,
    input  wire        voltage_present,
    input  wire [63:0] measure,
    output reg  [7:0]  relay_out,
    output reg  [7:0]  indicator_out,
    output reg  [15:0] analog_out,
    output reg  [1:0]  active_group,
    output reg  [3:0]  stage_start,
    output reg  [3:0]  stage_trip
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_BLK  = 2'b01;
    localparam [1:0] ST_START = 2'b10;
    localparam [1:0] ST_TRIP = 2'b11;

    // configuration
    reg [1:0]   default_group_select;
    reg         group_priority_order;  // 0: 1 to 4, 1: 4 to 1
    reg [15:0]  group_input_select;    // 4 bits per group: 0-7 di, 8-15 vi
    reg [3:0]   group_enable;
    reg         force_flag;
    reg [15:0]  stg_pickup  [0:3];
    reg [7:0]   stg_band    [0:3];
    reg [15:0]  stg_delay   [0:3];
    reg         stg_less    [0:3];
    reg         stg_latch   [0:3];
    reg         stg_arc     [0:3];
    reg         stg_uvblk   [0:3];
    reg [15:0]  stg_blkmap  [0:3];
    reg [15:0]  out_map     [0:3];     // [7:0] from start, [15:8] from trip
    reg [3:0]   force_start;
    reg [3:0]   force_trip;
    reg [7:0]   relay_force;
    reg         relay_force_en;
    reg [1:0]   stg_index;
    // state
    reg [1:0]   state   [0:3];
    reg [15:0]  dcount  [0:3];
    reg [31:0]  rcount  [0:3];
    reg         fault   [0:3];
    reg         held_s  [0:3];
    reg         held_t  [0:3];
    reg [31:0]  tout_cnt;
    reg [31:0]  frc_cnt;

    wire        wr_acc = psel & penable & pwrite;
    wire [15:0] blk_src = {virtual_input, discrete_input};
    wire [15:0] sel_src = {virtual_input, discrete_input};
    reg  [3:0]  grp_req;
    reg  [1:0]  next_group;
    reg  [7:0]  next_relay;
    reg  [7:0]  next_ind;
    integer     i;
    integer     g;
    integer     h;

    function [3:0] nib;
        input [15:0] v;
        input [1:0]  k;
        begin
            nib = v[k*4 +: 4];
        end
    endfunction

    // matrix blocking skips arc stages; the uv inhibit is fixed per stage
    function stg_blocked;
        input [1:0] k;
        begin
            stg_blocked = (!stg_arc[k] &&
                           (|(stg_blkmap[k] & blk_src))) ||   // see (RULE_13)
                          (stg_uvblk[k] && !voltage_present); // see (RULE_14)
        end
    endfunction

    // next comparator state; the dead band keeps noise from toggling it
    function stg_fault;
        input        was;
        input        less;
        input [15:0] meas;
        input [15:0] pick;
        input [7:0]  band;
        reg   [16:0] lo;
        reg   [16:0] hi;
        begin
            lo = {1'b0, meas} + {9'h000, band};
            hi = {1'b0, pick} + {9'h000, band};
            stg_fault = was;
            if (!less)
            begin
                if (meas > pick)
                    stg_fault = 1'b1;                      // see (RULE_22)
                else if (lo < {1'b0, pick})
                    stg_fault = 1'b0;                      // see (RULE_23)
            end
            else
            begin
                if (meas < pick)
                    stg_fault = 1'b1;
                else if ({1'b0, meas} > hi)
                    stg_fault = 1'b0;                      // see (RULE_23)
            end
        end
    endfunction

    always @*
    begin
        grp_req = 4'h0;
        for (g = 0; g < 4; g = g + 1)
            grp_req[g] = group_enable[g] &
                         sel_src[nib(group_input_select, g[1:0])]; // see (RULE_04) see (RULE_05)
        next_group = default_group_select;                     // see (RULE_01)
        if (group_priority_order)
        begin
            for (g = 0; g < 4; g = g + 1)
                if (grp_req[g])
                    next_group = g[1:0];                       // see (RULE_03)
        end
        else
        begin
            for (g = 3; g >= 0; g = g - 1)
                if (grp_req[g])
                    next_group = g[1:0];                       // see (RULE_02)
        end
    end

    always @*
    begin
        next_relay = 8'h00;
        next_ind = 8'h00;
        for (h = 0; h < 4; h = h + 1)
        begin
            if (held_s[h])
            begin
                next_relay = next_relay | out_map[h][7:0];     // see (RULE_18)
                next_ind = next_ind | out_map[h][7:0];
            end
            if (held_t[h])
            begin
                next_relay = next_relay | out_map[h][15:8];
                next_ind = next_ind | out_map[h][15:8];
            end
        end
        if (force_flag & relay_force_en)
            next_relay = relay_force;                          // see (RULE_17)
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            default_group_select <= 2'h0;
            group_priority_order <= 1'b0;
            group_input_select <= 16'h3210;
            group_enable <= 4'h0;
            force_flag <= 1'b0;
            force_start <= 4'h0;
            force_trip <= 4'h0;
            relay_force <= 8'h00;
            relay_force_en <= 1'b0;
            stg_index <= 2'h0;
            tout_cnt <= 32'h0;
            frc_cnt <= 32'h0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            relay_out <= 8'h00;
            indicator_out <= 8'h00;
            analog_out <= 16'h0000;
            active_group <= 2'h0;
            stage_start <= 4'h0;
            stage_trip <= 4'h0;
            for (i = 0; i < 4; i = i + 1)
            begin
                stg_pickup[i] <= 16'hFFFF;
                stg_band[i] <= 8'h00;
                stg_delay[i] <= 16'h0000;
                stg_less[i] <= 1'b0;
                stg_latch[i] <= 1'b0;
                stg_arc[i] <= 1'b0;
                stg_uvblk[i] <= 1'b0;
                stg_blkmap[i] <= 16'h0000;
                out_map[i] <= 16'h0000;
                state[i] <= ST_IDLE;
                dcount[i] <= 16'h0000;
                rcount[i] <= 32'h0;
                fault[i] <= 1'b0;
                held_s[i] <= 1'b0;
                held_t[i] <= 1'b0;
            end
        end
        else
        begin
            // zero-wait slave: answer in the first access cycle
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable & ~pwrite)
            begin
                case (paddr)
                `PSC_A_GROUP:  prdata <= {26'h0, group_priority_order,
                                          active_group, 1'b0,
                                          default_group_select};
                `PSC_A_GRPSEL: prdata <= {12'h0, group_enable,
                                          group_input_select};
                `PSC_A_FORCE:  prdata <= {23'h0, force_flag,
                                          force_trip, force_start};
                `PSC_A_STATUS: prdata <= {16'h0, stage_trip, stage_start,
                                          state[3], state[2], // see (RULE_06)
                                          state[1], state[0]};
                `PSC_A_OUTMAP: prdata <= {16'h0, out_map[stg_index]};
                `PSC_A_BLKMAP: prdata <= {16'h0, stg_blkmap[stg_index]};
                `PSC_A_STGCFG: prdata <= {stg_delay[stg_index],
                                          stg_pickup[stg_index]};
                `PSC_A_RELAY:  prdata <= {23'h0, relay_force_en,
                                          relay_force};
                `PSC_A_STGSEL: prdata <= {24'h0, stg_band[stg_index]};
                `PSC_A_ANALOG: prdata <= {16'h0, analog_out};
                default:       prdata <= 32'h0;
                endcase
            end
            // force flag times out after last panel activity
            if (panel_key)
                tout_cnt <= 32'h0;
            else if (force_flag && tout_cnt < TOUT_CYC - 1)
                tout_cnt <= tout_cnt + 32'h1;
            else if (force_flag)
                force_flag <= 1'b0;                            // see (RULE_16)
            if (frc_cnt != 32'h0)
                frc_cnt <= frc_cnt - 32'h1;
            else
            begin
                force_start <= 4'h0;
                force_trip <= 4'h0;
            end
            if (wr_acc)
            begin
                case (paddr)
                `PSC_A_GROUP:
                begin
                    default_group_select <= pwdata[1:0];
                    group_priority_order <= pwdata[5];
                end
                `PSC_A_GRPSEL:
                begin
                    group_input_select <= pwdata[15:0];
                    group_enable <= pwdata[19:16];
                end
                `PSC_A_FORCE:
                begin
                    force_flag <= pwdata[8];
                    tout_cnt <= 32'h0;
                    if (pwdata[8] | force_flag)
                    begin
                        force_start <= pwdata[3:0];            // see (RULE_15)
                        force_trip <= pwdata[7:4];
                        frc_cnt <= FORCE_CYC;
                    end
                end
                `PSC_A_KEY: tout_cnt <= 32'h0;
                `PSC_A_OUTMAP: out_map[stg_index] <= pwdata[15:0];
                `PSC_A_BLKMAP:
                begin
                    stg_blkmap[stg_index] <= pwdata[15:0];
                    stg_less[stg_index] <= pwdata[16];
                    stg_latch[stg_index] <= pwdata[17];
                    stg_arc[stg_index] <= pwdata[18];
                    stg_uvblk[stg_index] <= pwdata[19];
                end
                `PSC_A_STGCFG:
                begin
                    stg_pickup[stg_index] <= pwdata[15:0];
                    stg_delay[stg_index] <= pwdata[31:16];
                end
                `PSC_A_RELAY:
                begin
                    relay_force <= pwdata[7:0];
                    relay_force_en <= pwdata[8];
                end
                `PSC_A_STGSEL:
                begin
                    stg_index <= pwdata[9:8];
                    stg_band[pwdata[9:8]] <= pwdata[7:0];
                end
                `PSC_A_ANALOG:
                    if (force_flag)
                        analog_out <= pwdata[15:0];            // see (RULE_17)
                default: ;
                endcase
            end
            active_group <= next_group;
            relay_out <= next_relay;
            indicator_out <= next_ind;
            for (i = 0; i < 4; i = i + 1)
            begin
                fault[i] <= stg_fault(fault[i], stg_less[i],
                                      measure[i*16 +: 16],
                                      stg_pickup[i], stg_band[i]);
                case (state[i])
                ST_IDLE:
                begin
                    dcount[i] <= 16'h0000;
                    if (fault[i] | force_start[i] | force_trip[i])
                        state[i] <= ST_START;                  // see (RULE_07)
                end
                ST_START, ST_BLK:
                begin
                    if (!fault[i] && !force_start[i] && !force_trip[i])
                    begin
                        // drop out well inside the retardation limit
                        state[i] <= ST_IDLE;                   // see (RULE_19)
                    end
                    else if (force_trip[i])
                        state[i] <= ST_TRIP;
                    else if (stg_blocked(i[1:0]))
                        state[i] <= ST_BLK;                    // see (RULE_11)
                    else if (dcount[i] >= stg_delay[i])
                        state[i] <= ST_TRIP;                   // see (RULE_08)
                    else
                    begin
                        state[i] <= ST_START;
                        dcount[i] <= dcount[i] + 16'h0001;
                    end
                end
                ST_TRIP:
                    if (!fault[i] && !force_trip[i])
                        state[i] <= ST_IDLE;                   // see (RULE_09) see (RULE_12)
                default: state[i] <= ST_IDLE;
                endcase
                // a blocked stage with a fault goes from idle to blocked, not start
                if (state[i] == ST_IDLE && fault[i] && stg_blocked(i[1:0]))
                    state[i] <= ST_BLK;                        // see (RULE_10)
                // reset delay before outputs release, unless latched
                if (state[i] == ST_START || state[i] == ST_TRIP)
                begin
                    held_s[i] <= 1'b1;
                    rcount[i] <= 32'h0;
                    if (state[i] == ST_TRIP)
                        held_t[i] <= 1'b1;
                end
                else if (!stg_latch[i] && (held_s[i] | held_t[i]))
                begin
                    if (rcount[i] >= RESET_CYC - 1)
                    begin
                        held_s[i] <= 1'b0;                     // see (RULE_20)
                        held_t[i] <= 1'b0;                     // see (RULE_21)
                    end
                    else
                        rcount[i] <= rcount[i] + 32'h1;
                end
                stage_start[i] <= held_s[i];
                stage_trip[i] <= held_t[i];
            end
        end
    end
endmodule // psc_top

// ===== psc_checker.sv
`timescale 1ns/1ns
`include "psc_regs.vh"
module psc_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [7:0]  discrete_input,
    input wire [7:0]  virtual_input,
    input wire [7:0]  indicator_out,
    input wire [15:0] analog_out,
    input wire [1:0]  active_group,
    input wire [3:0]  stage_start,
    input wire [3:0]  stage_trip
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire      stir = psel && penable && pwrite;
    reg [2:0] quiet;
    reg [1:0] dflt;
    reg       dknown;
    // quiet counts settled cycles: group logic lags inputs by one register stage
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            quiet <= 3'h0;
        else if (stir || $changed({discrete_input, virtual_input}))
            quiet <= 3'h0;
        else if (quiet != 3'h4)
            quiet <= quiet + 3'h1;
    end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dknown <= 1'b0;
        else if (stir && paddr == `PSC_A_GROUP)
            dknown <= 1'b1;
    end
    always @(posedge pclk)
    begin
        if (stir && paddr == `PSC_A_GROUP)
            dflt <= pwdata[1:0];
    end
    chk_rdy_one: assert property (pready |=> !pready)
        else $error("pready stayed high");
    chk_rdy_access: assert property (pready |->
        psel && penable && $past(psel && !penable))
        else $error("pready outside access");
    chk_no_err: assert property (!pslverr)
        else $error("pslverr raised");
    chk_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("prdata moved without read");
    chk_group_quiet: assert property (quiet == 3'h4 |-> $stable(active_group))
        else $error("group moved without cause");
    chk_group_default: assert property (dknown && quiet == 3'h4 &&
        discrete_input == 8'h00 && virtual_input == 8'h00
        |-> active_group == dflt)
        else $error("default group not used");
    chk_analog_write: assert property ($changed(analog_out) |->
        $past(stir && paddr == `PSC_A_ANALOG))
        else $error("analog moved without write");
    chk_ind_idle: assert property (stage_start == 4'h0 &&
        stage_trip == 4'h0 && $past(stage_start) == 4'h0 &&
        $past(stage_trip) == 4'h0 |-> indicator_out == 8'h00)
        else $error("indicator without stage");
    chk_trip_cause: assert property (|(stage_trip & ~$past(stage_trip) &
        ~$past(stage_start)) |-> $past(stir) || $past(stir, 2))
        else $error("trip without start");
endmodule // psc_checker

bind psc_top psc_checker i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .discrete_input, .virtual_input,
    .indicator_out, .analog_out, .active_group, .stage_start, .stage_trip
);

// ===== psc_field.sv
`timescale 1ns/1ns
module psc_field (
    input  wire       pclk,
    input  wire [7:0] relay_out,
    output reg  [7:0] contact
);
    reg [7:0] coil;
    // contacts close one cycle after the coil, like a slow relay
    always @(posedge pclk)
    begin
        coil <= relay_out;
        contact <= coil;
    end
endmodule // psc_field

// ===== testbench.sv
`timescale 1ns/1ns
`include "psc_regs.vh"
module testbench;
    reg         pclk;
    reg         presetn;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    reg  [7:0]  discrete_input;
    reg  [7:0]  virtual_input;
    reg         panel_key;
    reg         voltage_present;
    reg  [63:0] measure;
    wire [7:0]  relay_out;
    wire [7:0]  indicator_out;
    wire [15:0] analog_out;
    wire [1:0]  active_group;
    wire [3:0]  stage_start;
    wire [3:0]  stage_trip;
    wire [7:0]  contact;
    reg  [63:0] note [$];
    reg  [63:0] n;
    reg  [31:0] r;
    reg         pr;
    integer     failures;
    integer     total_checks;
    integer     seed;
    integer     i;

    psc_top #(
        .TOUT_CYC   (32'hC8),
        .FORCE_CYC  (32'h32),
        .RESET_CYC  (32'h14),
        .RETARD_CYC (32'h0A)
    ) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .discrete_input, .virtual_input,
        .panel_key, .voltage_present, .measure, .relay_out,
        .indicator_out, .analog_out, .active_group, .stage_start,
        .stage_trip
    );
    psc_field i_field (.pclk, .relay_out, .contact);

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task end_sim;
    begin
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    task cmp(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task tick(input integer k);
    begin
        repeat (k) @(posedge pclk);
    end
    endtask

    // idle cycle after release keeps psel from being assigned twice at one edge
    task xfer(input w, input [11:0] a, input [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd(input [11:0] a, input [31:0] e, input [31:0] m);
    begin
        note.push_back({m, e & m});
        xfer(1'b0, a, 32'h0);
    end
    endtask

    function [1:0] pick(input [3:0] a, input hi, input [1:0] d);
        integer k;
        begin
            pick = d;
            for (k = 0; k < 4; k = k + 1)
                if (a[hi ? k : 3 - k])
                    pick = hi ? k[1:0] : 2'h3 - k[1:0];
        end
    endfunction

    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            n = note.pop_front();
            cmp(prdata & n[63:32], n[31:0]);
        end
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        failures = failures + 1;
        end_sim;
    end

    initial
    begin
        failures = 0;
        total_checks = 0;
        seed = 32'h79B8;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        discrete_input = 8'h00;
        virtual_input = 8'h00;
        panel_key = 1'b0;
        voltage_present = 1'b1;
        measure = 64'h0;
        tick(3);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h030, 32'h0, 32'hFFFFFFFF);
        // groups take discrete 0, virtual 1, discrete 2, discrete 3
        wr(`PSC_A_GRPSEL, 32'h000F3290);
        for (i = 0; i < 12; i = i + 1)
        begin
            pr = i[0];
            r = $random(seed);
            if (i % 4 == 3)
                r = 32'h0;
            wr(`PSC_A_GROUP, {26'h0, pr, 5'h02});
            discrete_input <= r[7:0];
            virtual_input <= r[15:8];
            tick(5);
            rd(`PSC_A_GROUP, {26'h0, pr, pick({r[3:2], r[9], r[0]}, pr,
                2'h2), 1'b0, 2'h2}, 32'h3F);
        end
        discrete_input <= 8'h00;
        virtual_input <= 8'h00;
        wr(`PSC_A_STGSEL, 32'h004);
        wr(`PSC_A_STGCFG, 32'h001E0064);
        wr(`PSC_A_BLKMAP, 32'h10);
        measure <= 64'hC8;
        tick(2);
        rd(`PSC_A_STATUS, 32'h2, 32'h3);
        discrete_input <= 8'h10;
        tick(40);
        rd(`PSC_A_STATUS, 32'h1, 32'h3);
        discrete_input <= 8'h00;
        tick(2);
        rd(`PSC_A_STATUS, 32'h2, 32'h3);
        tick(40);
        rd(`PSC_A_STATUS, 32'h1003, 32'h1003);
        discrete_input <= 8'h10;
        measure <= 64'h62;
        tick(4);
        rd(`PSC_A_STATUS, 32'h1003, 32'h1003);
        measure <= 64'h5A;
        tick(4);
        rd(`PSC_A_STATUS, 32'h1000, 32'h1000);
        tick(30);
        rd(`PSC_A_STATUS, 32'h0, 32'h1003);
        discrete_input <= 8'h00;
        measure <= 64'hC8;
        tick(10);
        measure <= 64'h0;
        tick(25);
        rd(`PSC_A_STATUS, 32'h0, 32'h1003);
        wr(`PSC_A_BLKMAP, 32'h80000);
        voltage_present <= 1'b0;
        measure <= 64'hC8;
        tick(4);
        rd(`PSC_A_STATUS, 32'h1, 32'h103);
        measure <= 64'h0;
        voltage_present <= 1'b1;
        wr(`PSC_A_STGSEL, 32'h100);
        wr(`PSC_A_OUTMAP, 32'h0201);
        wr(`PSC_A_FORCE, 32'h122);
        tick(4);
        cmp({24'h0, indicator_out}, 32'h03);
        wr(`PSC_A_RELAY, 32'h1A5);
        wr(`PSC_A_ANALOG, 32'h1234);
        tick(2);
        cmp({24'h0, contact}, 32'hA5);
        cmp({16'h0, analog_out}, 32'h1234);
        wr(`PSC_A_RELAY, 32'h0);
        tick(60);
        cmp({24'h0, indicator_out}, 32'h00);
        panel_key <= 1'b1;
        tick(1);
        panel_key <= 1'b0;
        tick(150);
        rd(`PSC_A_FORCE, 32'h100, 32'h100);
        tick(60);
        rd(`PSC_A_FORCE, 32'h0, 32'h100);
        end_sim;
    end
endmodule // testbench
